// file: src/agcreg_top.sv
/*
  agcreg_top: apb register bank for record-path gain control settings
  and the left-channel gain readback.
  assumes: gain engine sits outside, on core_clk, and pulses a sample strobe.
*/
// What this block does
// - left present gain readable, 8-bit signed half-dB, -6 to +58 dB.
// - one bit enables right-channel gain control; resets off.
// - 3-bit target code selects -5.5 down to -24 dBFS.
// - 2-bit gain hysteresis: zero disables, else 0.5, 1.0, 1.5 dB.
// - 2-bit level hysteresis: 1, 2, 4 dB; code three disables.
// - noise threshold zero disables the noise gate; resets to zero.
// - nonzero noise code: -30 dB at one, 2 dB lower per code.
// - 7-bit max gain caps at code times 0.5 dB; resets all ones.
// - max gain codes 116 to 127 all cap at 58 dB.
`timescale 1ns/1ps
`default_nettype none
module agcreg_top
  import agcreg_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  // gain engine side
  input  wire logic [7:0]  left_gain_now,
  input  wire logic        left_gain_stb,
  // settings to the right-channel engine
  output logic             right_agc_enable,
  output logic [7:0]       right_target_neg_half_dbfs,
  output logic             right_gain_hyst_on,
  output logic [1:0]       right_gain_hyst_half_db,
  output logic             right_level_hyst_on,
  output logic [2:0]       right_level_hyst_db,
  output logic             right_noise_gate_on,
  output logic [7:0]       right_noise_thresh_neg_db,
  output logic [6:0]       right_max_gain_half_db
);

  logic [7:0]      left_gain;
  logic [7:0]      ctrl1;
  logic [7:0]      ctrl2;
  logic [7:0]      maxg;
  agcreg_cfg_s     cfg;
  agcreg_decoded_s dec;

  // address decode
  wire        setup_ph   = psel & ~penable;
  wire        word_ok    = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
  wire [7:0]  reg_idx    = paddr[9:2];
  wire        hit_left   = word_ok && (reg_idx == IDX_LEFT_AGC_GAIN_READBACK);
  wire        hit_ctrl1  = word_ok && (reg_idx == IDX_RIGHT_AGC_ENABLE_TARGET_HYST);
  wire        hit_ctrl2  = word_ok && (reg_idx == IDX_RIGHT_AGC_HYST_NOISE_THRESH);
  wire        hit_maxg   = word_ok && (reg_idx == IDX_RIGHT_AGC_MAX_GAIN);
  wire        hit_any    = hit_left | hit_ctrl1 | hit_ctrl2 | hit_maxg;
  // writes to the read-only word count as errors, not silent drops
  wire        bad_access = ~hit_any | (pwrite & hit_left);
  wire        lane0      = pstrb[0];
  // a write lands only at the edge where the master samples pready
  wire        access_ph  = psel & penable & pready;
  wire        wr_take    = access_ph & pwrite & ~bad_access & lane0;
  wire [7:0]  wbyte      = pwdata[7:0];

  // reserved bits are masked so they always read zero
  wire [7:0]  next_ctrl1 = wbyte & MASK_RIGHT_AGC_CTRL1;
  wire [7:0]  next_ctrl2 = wbyte & MASK_RIGHT_AGC_CTRL2;
  wire [7:0]  next_maxg  = wbyte & MASK_RIGHT_AGC_MAXG;

  wire [7:0]  rd_byte    = hit_left  ? left_gain :
                           hit_ctrl1 ? ctrl1 :
                           hit_ctrl2 ? ctrl2 :
                           hit_maxg  ? maxg  : 8'h00;
  wire [31:0] next_prdata = (setup_ph & ~pwrite & hit_any) ? {24'h000000, rd_byte} : 32'h00000000;

  // one wait-free access: answer in the access phase after setup
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= setup_ph;
      pslverr <= setup_ph & bad_access;
      prdata  <= next_prdata;
    end
  end

  // writes land at the access edge; settings follow one edge later
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl1 <= RST_RIGHT_AGC_CTRL1;
      ctrl2 <= RST_RIGHT_AGC_CTRL2;
      maxg  <= RST_RIGHT_AGC_MAXG;
    end else begin
      if (wr_take & hit_ctrl1)
        ctrl1 <= next_ctrl1;
      if (wr_take & hit_ctrl2)
        ctrl2 <= next_ctrl2;
      if (wr_take & hit_maxg)
        maxg <= next_maxg;
    end
  end

  // engine gain clamped to the documented span
  wire signed [7:0] gain_in   = left_gain_now;
  wire [7:0]  next_left_gain  = (gain_in < GAIN_MIN_HALF_DB) ? GAIN_MIN_HALF_DB :
                                (gain_in > GAIN_MAX_HALF_DB) ? GAIN_MAX_HALF_DB : left_gain_now;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst)
      left_gain <= RST_LEFT_AGC_GAIN;
    else if (left_gain_stb)
      left_gain <= next_left_gain;
  end

  assign cfg.enable       = ctrl1[7];
  assign cfg.target       = ctrl1[6:4];
  assign cfg.gain_hyst    = ctrl1[1:0];
  assign cfg.level_hyst   = ctrl2[7:6];
  assign cfg.noise_thresh = ctrl2[5:1];
  assign cfg.max_gain     = maxg[6:0];

  agcreg_decode u_decode (
    .cfg (cfg),
    .dec (dec)
  );

  // settings registered so every output leaves a flip-flop
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      right_agc_enable           <= 1'b0;
      right_target_neg_half_dbfs <= RST_TARGET_NEG_HALF_DBFS;
      right_gain_hyst_on         <= 1'b0;
      right_gain_hyst_half_db    <= 2'h0;
      right_level_hyst_on        <= RST_LEVEL_HYST_ON;
      right_level_hyst_db        <= RST_LEVEL_HYST_DB;
      right_noise_gate_on        <= 1'b0;
      right_noise_thresh_neg_db  <= RST_NOISE_THRESH_NEG_DB;
      right_max_gain_half_db     <= RST_MAX_GAIN_HALF_DB;
    end else begin
      right_agc_enable           <= cfg.enable;
      right_target_neg_half_dbfs <= dec.target_neg_half_dbfs;
      right_gain_hyst_on         <= dec.gain_hyst_on;
      right_gain_hyst_half_db    <= dec.gain_hyst_half_db;
      right_level_hyst_on        <= dec.level_hyst_on;
      right_level_hyst_db        <= dec.level_hyst_db;
      right_noise_gate_on        <= dec.noise_gate_on;
      right_noise_thresh_neg_db  <= dec.noise_thresh_neg_db;
      right_max_gain_half_db     <= dec.max_gain_half_db;
    end
  end

  AST_MAXG_SAT: assert property (@(posedge core_clk) disable iff (rst)
    (maxg[6:0] >= 7'h74) |=> (right_max_gain_half_db == 7'h74))
    else $error("max gain not saturated at 58 dB");

  AST_MAXG_LIN: assert property (@(posedge core_clk) disable iff (rst)
    (maxg[6:0] < 7'h74) |=> (right_max_gain_half_db == $past(maxg[6:0])))
    else $error("max gain not equal to code");

  AST_NOISE_OFF: assert property (@(posedge core_clk) disable iff (rst)
    (ctrl2[5:1] == 5'h00) |=> !right_noise_gate_on)
    else $error("noise gate on with zero threshold");

  AST_NOISE_VAL: assert property (@(posedge core_clk) disable iff (rst)
    (ctrl2[5:1] == 5'h1f) |=> (right_noise_gate_on && right_noise_thresh_neg_db == 8'h5a))
    else $error("noise threshold code 31 not -90 dB");

  AST_LEVEL_HYST: assert property (@(posedge core_clk) disable iff (rst)
    (ctrl2[7:6] == 2'h2) |=> (right_level_hyst_on && right_level_hyst_db == 3'h4))
    else $error("level hysteresis code 2 not 4 dB");

  AST_GAIN_HYST: assert property (@(posedge core_clk) disable iff (rst)
    (ctrl1[1:0] == 2'h0) |=> !right_gain_hyst_on)
    else $error("gain hysteresis on at code zero");

  AST_TARGET: assert property (@(posedge core_clk) disable iff (rst)
    (ctrl1[6:4] == 3'h7) |=> (right_target_neg_half_dbfs == 8'h30))
    else $error("target code 7 not -24 dBFS");

  AST_ENABLE: assert property (@(posedge core_clk) disable iff (rst)
    (wr_take && hit_ctrl1) |-> ##2 (right_agc_enable == $past(pwdata[7], 2)))
    else $error("enable bit not following write");

  AST_RSVD: assert property (@(posedge core_clk) disable iff (rst)
    (ctrl1[3:2] == 2'h0) && (ctrl2[0] == 1'b0) && (maxg[7] == 1'b0))
    else $error("reserved bit reads nonzero");

  AST_GAIN_TRACK: assert property (@(posedge core_clk) disable iff (rst)
    left_gain_stb |=> ($signed(left_gain) >= -8'sd12 && $signed(left_gain) <= 8'sd116))
    else $error("left gain readback out of span");

  AST_GAIN_CAPTURE: assert property (@(posedge core_clk) disable iff (rst)
    (left_gain_stb && $signed(left_gain_now) >= -8'sd12 && $signed(left_gain_now) <= 8'sd116)
    |=> (left_gain == $past(left_gain_now)))
    else $error("in-span left gain not captured on strobe");

  AST_GAIN_HOLD: assert property (@(posedge core_clk) disable iff (rst)
    !left_gain_stb |=> $stable(left_gain))
    else $error("left gain readback changed without strobe");

  AST_RO_WRITE: assert property (@(posedge core_clk) disable iff (rst)
    (psel && penable && pwrite && hit_left) |-> pslverr)
    else $error("write to gain readback not refused");

  AST_RDATA_UPPER: assert property (@(posedge core_clk) disable iff (rst)
    pready |-> (prdata[31:8] == 24'h000000))
    else $error("read data upper bits nonzero");

  AST_TARGET_ZERO: assert property (@(posedge core_clk) disable iff (rst)
    (ctrl1[6:4] == 3'h0) |=> (right_target_neg_half_dbfs == 8'h0b))
    else $error("target code 0 not -5.5 dBFS");

  AST_GAIN_HYST_VAL: assert property (@(posedge core_clk) disable iff (rst)
    (ctrl1[1:0] != 2'h0) |=> (right_gain_hyst_on && right_gain_hyst_half_db == $past(ctrl1[1:0])))
    else $error("gain hysteresis not following code");

  AST_LEVEL_OFF: assert property (@(posedge core_clk) disable iff (rst)
    (ctrl2[7:6] == 2'h3) |=> !right_level_hyst_on)
    else $error("level hysteresis on at code 3");

  AST_NOISE_ONE: assert property (@(posedge core_clk) disable iff (rst)
    (ctrl2[5:1] == 5'h01) |=> (right_noise_gate_on && right_noise_thresh_neg_db == 8'h1e))
    else $error("noise threshold code 1 not -30 dB");

endmodule // agcreg_top
`default_nettype wire

// file: src/agcreg_pkg.sv
/*
  agcreg_pkg: offsets, field layout, reset values and decode constants
  for the record-path gain control register bank.
  assumes: 32-bit apb data, one register per aligned word.
*/
package agcreg_pkg;

  // printed offsets are not all multiples of four: they are indices
  localparam logic [7:0] IDX_LEFT_AGC_GAIN_READBACK      = 8'h5d;
  localparam logic [7:0] IDX_RIGHT_AGC_ENABLE_TARGET_HYST = 8'h5e;
  localparam logic [7:0] IDX_RIGHT_AGC_HYST_NOISE_THRESH = 8'h5f;
  localparam logic [7:0] IDX_RIGHT_AGC_MAX_GAIN          = 8'h60;

  localparam logic [7:0] RST_LEFT_AGC_GAIN   = 8'h00;
  localparam logic [7:0] RST_RIGHT_AGC_CTRL1 = 8'h00;
  localparam logic [7:0] RST_RIGHT_AGC_CTRL2 = 8'h00;
  localparam logic [7:0] RST_RIGHT_AGC_MAXG  = 8'h7f;

  // decoded settings while in reset, matching the reset field codes
  localparam logic [7:0] RST_TARGET_NEG_HALF_DBFS = 8'h0b;
  localparam logic       RST_LEVEL_HYST_ON        = 1'b1;
  localparam logic [2:0] RST_LEVEL_HYST_DB        = 3'h1;
  localparam logic [7:0] RST_NOISE_THRESH_NEG_DB  = 8'h1c;
  localparam logic [6:0] RST_MAX_GAIN_HALF_DB     = 7'h74;

  // writable bit masks; reserved bits read as zero
  localparam logic [7:0] MASK_RIGHT_AGC_CTRL1 = 8'hf3;
  localparam logic [7:0] MASK_RIGHT_AGC_CTRL2 = 8'hfe;
  localparam logic [7:0] MASK_RIGHT_AGC_MAXG  = 8'h7f;

  // gain range in half-dB steps
  localparam logic signed [7:0] GAIN_MIN_HALF_DB = 8'hf4;
  localparam logic signed [7:0] GAIN_MAX_HALF_DB = 8'h74;
  localparam logic [6:0]        MAXG_SAT_CODE    = 7'h74;

  // noise threshold: code 1 is -30 dB, 2 dB per code
  localparam logic [7:0] NOISE_BASE_DB = 8'h1e;
  localparam logic [7:0] NOISE_STEP_DB = 8'h02;

  typedef struct packed {
    logic       enable;
    logic [2:0] target;
    logic [1:0] gain_hyst;
    logic [1:0] level_hyst;
    logic [4:0] noise_thresh;
    logic [6:0] max_gain;
  } agcreg_cfg_s;

  typedef struct packed {
    logic        gain_hyst_on;
    logic [1:0]  gain_hyst_half_db;
    logic        level_hyst_on;
    logic [2:0]  level_hyst_db;
    logic        noise_gate_on;
    logic [7:0]  noise_thresh_neg_db;
    logic [6:0]  max_gain_half_db;
    logic [7:0]  target_neg_half_dbfs;
  } agcreg_decoded_s;

  // target in negative half-dBFS units
  function automatic logic [7:0] agcreg_target(input logic [2:0] code);
    case (code)
      3'h0:    agcreg_target = 8'h0b;
      3'h1:    agcreg_target = 8'h10;
      3'h2:    agcreg_target = 8'h14;
      3'h3:    agcreg_target = 8'h18;
      3'h4:    agcreg_target = 8'h1c;
      3'h5:    agcreg_target = 8'h22;
      3'h6:    agcreg_target = 8'h28;
      default: agcreg_target = 8'h30;
    endcase
  endfunction

endpackage

// file: src/agcreg_decode.sv
/*
  agcreg_decode: turns raw right-channel fields into physical settings.
  assumes: fields come from registers on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module agcreg_decode
  import agcreg_pkg::*;
(
  // raw fields
  input  wire agcreg_cfg_s     cfg,
  // decoded settings
  output agcreg_decoded_s dec
);

  wire [7:0] noise_steps = {3'h0, cfg.noise_thresh} - 8'h01;

  assign dec.gain_hyst_on          = (cfg.gain_hyst != 2'h0);
  assign dec.gain_hyst_half_db     = cfg.gain_hyst;
  assign dec.level_hyst_on         = (cfg.level_hyst != 2'h3);
  assign dec.level_hyst_db         = 3'(3'h1 << cfg.level_hyst);
  assign dec.noise_gate_on         = (cfg.noise_thresh != 5'h00);
  assign dec.noise_thresh_neg_db   = NOISE_BASE_DB + 8'(noise_steps << 1);
  assign dec.max_gain_half_db      = (cfg.max_gain > MAXG_SAT_CODE) ? MAXG_SAT_CODE
                                                                   : cfg.max_gain;
  assign dec.target_neg_half_dbfs  = agcreg_target(cfg.target);

endmodule // agcreg_decode
`default_nettype wire

// file: bench/agcreg_tb.sv
/*
  tb: self-checking bench for agcreg_top over apb, queue-based read checks.
  assumes: zero-wait apb slave, registered decoded settings, rst active high.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  import agcreg_pkg::*;
  logic        core_clk, rst, psel, penable, pwrite, left_gain_stb, en_o, ghon, lhon, ngon;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb, strb;
  logic [7:0]  left_gain_now, tgt, nth, c1, c2, c3, g;
  logic        pready, pslverr;
  logic [1:0]  ghd;
  logic [2:0]  lhd;
  logic [6:0]  mgo;
  logic [32:0] exp_q[$];
  logic [32:0] e;
  logic [7:0]  ttab[8] = '{8'h0b, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h22, 8'h28, 8'h30};
  int          fail_count, tests_run, cyc, k;
  agcreg_top u_agcreg_top (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .left_gain_now(left_gain_now), .left_gain_stb(left_gain_stb), .right_agc_enable(en_o),
    .right_target_neg_half_dbfs(tgt), .right_gain_hyst_on(ghon), .right_gain_hyst_half_db(ghd),
    .right_level_hyst_on(lhon), .right_level_hyst_db(lhd), .right_noise_gate_on(ngon),
    .right_noise_thresh_neg_db(nth), .right_max_gain_half_db(mgo));
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cmp(input string n, input logic [31:0] x, input logic [31:0] y);
    tests_run++;
    if (y !== x) begin
      fail_count++;
      $display("MISMATCH %s exp %h got %h", n, x, y);
    end
  endtask
  // bus answers are matched in order against notes queued by the driver
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      results();
    end
    if (pready === 1'b1) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 33'h1_dead_beef;
      cmp("prdata", e[31:0], prdata);
      cmp("pslverr", {31'h0, e[32]}, {31'h0, pslverr});
    end
  end
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] x);
    exp_q.push_back(x);
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= strb;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [11:0] ad(input logic [7:0] i);
    return {2'b00, i, 2'b00};
  endfunction
  // write, read back masked value, then check decoded settings from c1..c3
  task automatic wr_rd(input logic [7:0] i, input logic [7:0] v, input logic [7:0] m);
    apb(1'b1, ad(i), {24'h0, v}, 33'h0);
    apb(1'b0, ad(i), 32'h0, {25'h0, v & m});
    @(negedge core_clk);
    cmp("enable", {31'h0, c1[7]}, {31'h0, en_o});
    cmp("target", {24'h0, ttab[c1[6:4]]}, {24'h0, tgt});
    cmp("ghyst_on", {31'h0, c1[1:0] != 2'b00}, {31'h0, ghon});
    if (c1[1:0] != 2'b00) cmp("ghyst", {30'h0, c1[1:0]}, {30'h0, ghd});
    cmp("lhyst_on", {31'h0, c2[7:6] != 2'b11}, {31'h0, lhon});
    if (c2[7:6] != 2'b11) cmp("lhyst", 32'h1 << c2[7:6], {29'h0, lhd});
    cmp("ngate_on", {31'h0, c2[5:1] != 5'h00}, {31'h0, ngon});
    if (c2[5:1] != 5'h00) cmp("nthresh", 32'd28 + 32'd2 * c2[5:1], {24'h0, nth});
    cmp("maxgain", (c3[6:0] >= 7'd116) ? 32'd116 : {25'h0, c3[6:0]}, {25'h0, mgo});
  endtask
  initial begin
    {psel, penable, pwrite, left_gain_stb, paddr, pwdata, left_gain_now} = '0;
    strb = 4'hf;
    pstrb = 4'hf;
    rst = 1'b1;
    c1 = 8'h00;
    c2 = 8'h00;
    c3 = 8'h7f;
    void'($urandom(99));
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    apb(1'b0, ad(8'h5d), 32'h0, 33'h0);
    wr_rd(8'h60, c3, 8'h7f);
    // refused: unmapped, misaligned, write to read-only gain
    apb(1'b0, ad(8'h61), 32'h0, 33'h1_0000_0000);
    apb(1'b0, 12'h179, 32'h0, 33'h1_0000_0000);
    apb(1'b1, ad(8'h5d), 32'h55, 33'h1_0000_0000);
    for (k = 0; k < 8; k++) begin
      c1 = {k[0], k[2:0], 2'b11, k[1:0]};
      wr_rd(8'h5e, c1, 8'hf3);
      c1 = c1 & 8'hf3;
    end
    for (k = 0; k < 4; k++) begin
      c2 = {k[1:0], (k == 0) ? 5'h00 : (k == 1) ? 5'h01 : (k == 2) ? 5'h1f : 5'($urandom_range(1, 31)), 1'b1};
      wr_rd(8'h5f, c2, 8'hfe);
      c2 = c2 & 8'hfe;
    end
    for (k = 0; k < 5; k++) begin
      c3 = {1'b1, (k < 4) ? 7'(k * 40 - (k == 3 ? 4 : 0) - (k == 1 ? 25 : 0)) : 7'($urandom_range(0, 127))};
      wr_rd(8'h60, c3, 8'h7f);
      c3 = c3 & 8'h7f;
    end
    // strobe without byte zero leaves the register untouched
    strb = 4'he;
    apb(1'b1, ad(8'h5e), 32'h0, 33'h0);
    strb = 4'hf;
    wr_rd(8'h60, c3, 8'h7f);
    apb(1'b0, ad(8'h5e), 32'h0, {25'h0, c1});
    for (k = 0; k < 6; k++) begin
      g = (k == 0) ? 8'hf4 : (k == 1) ? 8'h74 : (k == 2) ? 8'h7f : (k == 3) ? 8'h00 :
          (k == 4) ? 8'h80 : 8'($urandom_range(0, 116));
      @(posedge core_clk);
      left_gain_now <= g;
      left_gain_stb <= 1'b1;
      @(posedge core_clk);
      left_gain_stb <= 1'b0;
      left_gain_now <= 8'($urandom);
      apb(1'b0, ad(8'h5d), 32'h0,
          {25'h0, ($signed(g) > 8'sd116) ? 8'h74 : ($signed(g) < -8'sd12) ? 8'hf4 : g});
    end
    // second reset mid-run restores defaults
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    c1 = 8'h00;
    c2 = 8'h00;
    c3 = 8'h7f;
    wr_rd(8'h5e, 8'h00, 8'hf3);
    apb(1'b0, ad(8'h60), 32'h0, 33'h7f);
    apb(1'b0, ad(8'h5d), 32'h0, 33'h0);
    repeat (3) @(posedge core_clk);
    cmp("queue_left", 32'h0, exp_q.size());
    results();
  end
endmodule // tb
`default_nettype wire
